// [common/shrp_pkg.sv]
// constants and carrier types for the serial host register port
// assumes a 10 MHz system clock and a slow host serial clock
package shrp_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h00;
	localparam logic [5:0] ADDR_IRQ_STATUS = 6'h01;
	localparam logic [5:0] ADDR_LIVE_CONDITION = 6'h02;
	localparam logic [5:0] ADDR_CLOCK_FIFO_CONTROL = 6'h03;
	localparam logic [5:0] ADDR_TIMING_MODE_CONTROL = 6'h04;
	localparam logic [5:0] ADDR_LOOPBACK_CONTROL = 6'h05;
	localparam logic [5:0] ADDR_PART_IDENTIFIER = 6'h3E;
	localparam logic [5:0] ADDR_REVISION_IDENTIFIER = 6'h3F;
	// ****************************************
	// field layout and writable masks
	// ****************************************
	localparam int IRQ_SOURCES = 5;
	localparam logic [7:0] MASK_IRQ = 8'h1F;
	localparam logic [7:0] MASK_CLOCK_FIFO = 8'h5F;
	localparam logic [7:0] MASK_TIMING_MODE = 8'h7D;
	localparam logic [7:0] MASK_LOOPBACK = 8'h07;
	localparam logic [7:0] RESET_REG = 8'h00;
	// ****************************************
	// frame layout
	// ****************************************
	localparam int FRAME_BITS = 16;
	localparam logic [4:0] BIT_RW = 5'h01;
	localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
	localparam logic [4:0] BIT_DUMMY = 5'h08;
	localparam logic [4:0] BIT_DATA_FIRST = 5'h09;
	localparam logic [4:0] BIT_FRAME_LAST = 5'h10;
	localparam logic OP_WRITE = 1'b0;
	localparam logic OP_READ = 1'b1;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int RESET_HOLD_MS = 10;
	localparam int RESET_HOLD_CYCLES = (CLK_HZ / 1000) * RESET_HOLD_MS;
	// ****************************************
	// carrier types
	// ****************************************
	typedef struct packed {
		logic rw;
		logic [5:0] addr;
		logic [7:0] data;
	} shrp_frame_t;
	typedef enum logic [1:0] {
		SHRP_IDLE = 2'b00,
		SHRP_SHIFT = 2'b01,
		SHRP_HOLD = 2'b11
	} shrp_state_t;
endpackage

// [hw/shrp_sync.sv]
// two flip-flop synchroniser for pins from outside the system clock
// assumes nothing reads the first stage but the second
`timescale 1ns/100ps
module shrp_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_async,
	output logic o_sync
);
	logic stage1;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage1 <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule // shrp_sync

// [hw/shrp_port.sv]
// serial host port with register file for a transceiver
// assumes host pins are asynchronous to i_clk_sys, which is much faster
// What this block and its host do
// R1 - frame is sixteen bits while select low
// R2 - sample data in on serial clock rise
// R3 - no register update before sixteen bits
// R4 - host raises select after every frame
// R5 - host sends every field lsb first
// R6 - first bit zero writes, one reads
// R7 - bits two to seven carry address
// R8 - eighth bit ignored, readout prepares
// R9 - bits nine to sixteen carry data
// R10 - write commits when select rises
// R11 - data out changes on clock falls
// R12 - read bits out on falls eight-fifteen
// R13 - reset low over 10 ms restores defaults
// R14 - data out and interrupt are optional
// R15 - enable zero blocks source, default zero
// R16 - status sets on change, clears on read
// R17 - interrupt when enabled status bit set
// R18 - reserved writes ignored, read as zero
`timescale 1ns/100ps
module shrp_port
	import shrp_pkg::*;
#(
	parameter int RESET_HOLD = RESET_HOLD_CYCLES,
	parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] REVISION_IDENTIFIER = 8'h01 // arbitrary value
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_host_select_n,
	input wire logic i_host_clock,
	input wire logic i_host_serial_in,
	input wire logic i_host_reset_n,
	input wire logic [IRQ_SOURCES-1:0] i_condition,
	output logic o_host_serial_out,
	output logic o_host_serial_out_en,
	output logic o_irq_n,
	output logic [7:0] o_clock_fifo_control,
	output logic [7:0] o_timing_mode_control,
	output logic [7:0] o_loopback_control
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic sel_n_s;
	logic sclk_s;
	logic serial_in_s;
	logic hrst_n_s;
	logic [IRQ_SOURCES-1:0] cond_s;

	shrp_sync #(.RESET_VAL(1'b1)) u_sync_sel (.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n), .i_async(i_host_select_n), .o_sync(sel_n_s));
	shrp_sync #(.RESET_VAL(1'b0)) u_sync_clk (.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n), .i_async(i_host_clock), .o_sync(sclk_s));
	shrp_sync #(.RESET_VAL(1'b0)) u_sync_serial_in (.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n), .i_async(i_host_serial_in), .o_sync(serial_in_s));
	shrp_sync #(.RESET_VAL(1'b1)) u_sync_rst (.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n), .i_async(i_host_reset_n), .o_sync(hrst_n_s));

	genvar g;
	generate
		for (g = 0; g < IRQ_SOURCES; g++) begin : g_cond
			shrp_sync #(.RESET_VAL(1'b0)) u_sync_cond (.i_clk_sys(i_clk_sys),
				.i_reset_n(i_reset_n), .i_async(i_condition[g]),
				.o_sync(cond_s[g]));
		end
	endgenerate

	// ****************************************
	// edge detection
	// ****************************************
	logic sclk_d;
	logic sel_n_d;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_rise;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sclk_d <= 1'b0;
			sel_n_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			sel_n_d <= sel_n_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_d & ~sel_n_s; // R2
	assign sclk_fall = ~sclk_s & sclk_d & ~sel_n_s; // R11
	assign sel_rise = sel_n_s & ~sel_n_d; // R10

	// ****************************************
	// host reset hold counter
	// ****************************************
	logic [$clog2(RESET_HOLD+1)-1:0] hold_count;
	logic soft_reset;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold_count <= '0;
			soft_reset <= 1'b0;
		end else if (hrst_n_s) begin
			hold_count <= '0;
			soft_reset <= 1'b0;
		end else if (hold_count == $bits(hold_count)'(RESET_HOLD)) begin
			soft_reset <= 1'b1; // R13
		end else begin
			hold_count <= hold_count + 1'b1;
		end
	end

	// ****************************************
	// frame shifter
	// ****************************************
	shrp_state_t state;
	logic [4:0] bit_count;
	shrp_frame_t frame;
	logic frame_done;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= SHRP_IDLE;
			bit_count <= 5'h00;
		end else if (sel_n_s) begin
			state <= SHRP_IDLE;
			bit_count <= 5'h00;
		end else begin
			unique case (state)
				SHRP_IDLE: begin
					state <= SHRP_SHIFT;
				end
				SHRP_SHIFT: begin
					if (sclk_rise) begin
						bit_count <= bit_count + 1'b1;
						if (bit_count + 1'b1 == BIT_FRAME_LAST) begin
							state <= SHRP_HOLD; // R1
						end
					end
				end
				SHRP_HOLD: begin
					state <= SHRP_HOLD; // R4
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			frame <= '0;
		end else if (state != SHRP_HOLD && sclk_rise && !sel_n_s) begin
			if (bit_count + 1'b1 == BIT_RW) begin
				frame.rw <= serial_in_s; // R6
			end else if (bit_count + 1'b1 <= BIT_ADDR_LAST) begin
				frame.addr <= {serial_in_s, frame.addr[5:1]}; // R7
			end else if (bit_count + 1'b1 >= BIT_DATA_FIRST) begin
				frame.data <= {serial_in_s, frame.data[7:1]}; // R9
			end
			// dummy bit falls through unused R8
		end
	end

	assign frame_done = (state == SHRP_HOLD); // R3
	logic commit;
	assign commit = sel_rise & frame_done & (frame.rw == OP_WRITE); // R10

	// ****************************************
	// register file
	// ****************************************
	logic [7:0] irq_enable;
	logic [7:0] irq_status;
	logic [7:0] clock_fifo_control;
	logic [7:0] timing_mode_control;
	logic [7:0] loopback_control;
	logic [IRQ_SOURCES-1:0] cond_d;
	logic status_read;

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_enable <= RESET_REG;
			clock_fifo_control <= RESET_REG;
			timing_mode_control <= RESET_REG;
			loopback_control <= RESET_REG;
		end else if (soft_reset) begin
			irq_enable <= RESET_REG; // R13 R15
			clock_fifo_control <= RESET_REG;
			timing_mode_control <= RESET_REG;
			loopback_control <= RESET_REG;
		end else if (commit) begin
			unique case (frame.addr)
				ADDR_IRQ_ENABLE: irq_enable <= frame.data & MASK_IRQ; // R18
				ADDR_CLOCK_FIFO_CONTROL:
					clock_fifo_control <= frame.data & MASK_CLOCK_FIFO;
				ADDR_TIMING_MODE_CONTROL:
					timing_mode_control <= frame.data & MASK_TIMING_MODE;
				ADDR_LOOPBACK_CONTROL:
					loopback_control <= frame.data & MASK_LOOPBACK;
				default: ; // R18
			endcase
		end
	end

	// status clears at the end of a read frame of its address
	assign status_read = sel_rise & frame_done & (frame.rw == OP_READ)
		& (frame.addr == ADDR_IRQ_STATUS);

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cond_d <= '0;
			irq_status <= RESET_REG;
		end else begin
			cond_d <= cond_s;
			if (soft_reset) begin
				irq_status <= RESET_REG;
			end else begin
				// set wins over clear R16
				irq_status <= ((status_read ? 8'h00 : irq_status)
					| 8'(cond_s ^ cond_d)) & MASK_IRQ; // R16
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq_n <= 1'b1;
		end else begin
			o_irq_n <= ~|(irq_status & irq_enable); // R14 R15 R17
		end
	end

	assign o_clock_fifo_control = clock_fifo_control;
	assign o_timing_mode_control = timing_mode_control;
	assign o_loopback_control = loopback_control;

	// ****************************************
	// read data and serial output
	// ****************************************
	logic [7:0] read_word;
	logic [7:0] shift_out;

	always_comb begin
		unique case (frame.addr)
			ADDR_IRQ_ENABLE: read_word = irq_enable;
			ADDR_IRQ_STATUS: read_word = irq_status;
			ADDR_LIVE_CONDITION: read_word = 8'(cond_s);
			ADDR_CLOCK_FIFO_CONTROL: read_word = clock_fifo_control;
			ADDR_TIMING_MODE_CONTROL: read_word = timing_mode_control;
			ADDR_LOOPBACK_CONTROL: read_word = loopback_control;
			ADDR_PART_IDENTIFIER: read_word = PART_ID;
			ADDR_REVISION_IDENTIFIER: read_word = REVISION_IDENTIFIER;
			default: read_word = 8'h00; // R18
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			shift_out <= 8'h00;
			o_host_serial_out <= 1'b0;
			o_host_serial_out_en <= 1'b0;
		end else if (sel_n_s) begin
			o_host_serial_out_en <= 1'b0;
			o_host_serial_out <= 1'b0;
		end else if (sclk_fall && frame.rw == OP_READ) begin
			if (bit_count == BIT_DUMMY) begin
				o_host_serial_out <= read_word[0]; // R12
				shift_out <= {1'b0, read_word[7:1]};
				o_host_serial_out_en <= 1'b1;
			end else if (bit_count > BIT_DUMMY && bit_count < BIT_FRAME_LAST) begin
				o_host_serial_out <= shift_out[0]; // R11 R12
				shift_out <= {1'b0, shift_out[7:1]};
			end
		end
	end
endmodule // shrp_port

// [dv/shrp_port_monitor.sv]
// checker for the serial host register port
// assumes host pins move on system clock falls
`timescale 1ns/100ps
module shrp_port_monitor
	import shrp_pkg::*;
#(
	parameter int RESET_HOLD = RESET_HOLD_CYCLES
) (
	input logic i_clk_sys,
	input logic i_reset_n,
	input logic i_host_select_n,
	input logic i_host_clock,
	input logic i_host_serial_in,
	input logic i_host_reset_n,
	input logic o_host_serial_out,
	input logic o_host_serial_out_en,
	input logic o_irq_n,
	input logic [7:0] o_clock_fifo_control,
	input logic [7:0] o_timing_mode_control,
	input logic [7:0] o_loopback_control
);
	logic clk_q;
	logic [15:0] sh;
	logic [4:0] cnt;
	int hold;
	logic [23:0] ctl;
	assign ctl = {o_clock_fifo_control, o_timing_mode_control,
		o_loopback_control};
	// ******
	// frame and reset tracking
	// ******
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clk_q <= 1'b0;
			sh <= 16'h0000;
			cnt <= 5'h00;
		end else begin
			clk_q <= i_host_clock;
			if (i_host_select_n) begin
				cnt <= 5'h00;
			end else if (i_host_clock && !clk_q) begin
				sh <= {i_host_serial_in, sh[15:1]};
				cnt <= cnt + 5'h01;
			end
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold <= 0;
		end else if (i_host_reset_n) begin
			hold <= 0;
		end else if (hold < RESET_HOLD + 12) begin
			hold <= hold + 1;
		end
	end
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);
	// ******
	// checks
	// ******
	chk_en_start: assert property (
		$rose(o_host_serial_out_en) |-> cnt inside {5'h08, 5'h09})
		else $error("output enable rose at wrong bit");
	chk_en_write: assert property (
		cnt == 5'h10 && !sh[0] |-> !o_host_serial_out_en)
		else $error("output enabled in a write");
	chk_en_release: assert property (
		$rose(i_host_select_n) |-> ##[1:6] !o_host_serial_out_en)
		else $error("output enable stuck after frame");
	chk_out_stable: assert property (
		i_host_clock && $past(i_host_clock, 2) |-> $stable(o_host_serial_out))
		else $error("data out moved while clock high");
	chk_commit_data: assert property (
		$rose(i_host_select_n) && cnt == 5'h10 && !sh[0] &&
		sh[6:1] == ADDR_LOOPBACK_CONTROL |->
		##[2:6] o_loopback_control == (sh[15:8] & MASK_LOOPBACK))
		else $error("loopback write not committed");
	chk_no_early: assert property (
		$changed(ctl) |-> $past(i_host_select_n, 2))
		else $error("register changed inside a frame");
	chk_short_frame: assert property (
		$rose(i_host_select_n) && cnt < 5'h10 |=> $stable(ctl) [*6])
		else $error("short frame changed a register");
	chk_host_reset: assert property (
		hold > RESET_HOLD + 8 |-> ctl == 24'h000000 && o_irq_n)
		else $error("host reset did not clear");
	chk_reserved_bits: assert property (
		(ctl & ~{MASK_CLOCK_FIFO, MASK_TIMING_MODE, MASK_LOOPBACK}) == 24'h0)
		else $error("reserved control bit set");
	cover property ($rose(o_host_serial_out_en));
	cover property ($fell(o_irq_n));
	cover property ($rose(i_host_select_n) && cnt == 5'h10);
endmodule // shrp_port_monitor

bind shrp_port shrp_port_monitor #(.RESET_HOLD(RESET_HOLD)) u_mon (
	.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
	.i_host_select_n(i_host_select_n), .i_host_clock(i_host_clock),
	.i_host_serial_in(i_host_serial_in), .i_host_reset_n(i_host_reset_n),
	.o_host_serial_out(o_host_serial_out),
	.o_host_serial_out_en(o_host_serial_out_en), .o_irq_n(o_irq_n),
	.o_clock_fifo_control(o_clock_fifo_control),
	.o_timing_mode_control(o_timing_mode_control),
	.o_loopback_control(o_loopback_control)
);

// [dv/shrp_host_model.sv]
// host model driving frames onto the serial host port
// assumes callers enter its tasks at a system clock fall
`timescale 1ns/100ps
module shrp_host_model (
	input logic i_clk_sys,
	input logic i_host_serial_out,
	output logic o_host_select_n,
	output logic o_host_clock,
	output logic o_host_serial_in,
	output logic o_host_reset_n
);
	initial begin
		o_host_select_n = 1'b1;
		o_host_clock = 1'b0;
		o_host_serial_in = 1'b0;
		o_host_reset_n = 1'b1;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	// one frame of n bits; read bits land in rd
	task automatic xfer(input logic [15:0] f, input int n,
		output logic [7:0] rd);
		rd = 8'h00;
		o_host_select_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_host_serial_in = f[i];
			wait_n(4);
			if (i > 7) begin
				rd[i - 8] = i_host_serial_out;
			end
			o_host_clock = 1'b1;
			wait_n(4);
			o_host_clock = 1'b0;
		end
		wait_n(4);
		o_host_select_n = 1'b1;
		o_host_serial_in = ~o_host_serial_in;
		wait_n(10);
	endtask
	task automatic pulse_reset(input int n);
		o_host_reset_n = 1'b0;
		wait_n(n);
		o_host_reset_n = 1'b1;
	endtask
endmodule // shrp_host_model

// [dv/testbench.sv]
// self-checking bench for the serial host register port
// assumes the host model paces frames at an 800 ns serial clock
`timescale 1ns/100ps
module testbench
	import shrp_pkg::*;
;
	localparam int HOLD = 20;
	localparam logic [7:0] PART = 8'hA5; // arbitrary value
	localparam logic [7:0] REV = 8'h03; // arbitrary value
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] cond = 5'h00;
	logic sel_n, sclk, host_serial_in, hrst_n, irq_n;
	logic host_serial_out, host_serial_out_en, host_serial_line;
	logic [7:0] c_fifo, c_mode, c_loop, junk;
	int miscompares = 0;
	int cmp_count = 0;
	always #50 clk = ~clk;
	shrp_port #(.RESET_HOLD(HOLD), .PART_ID(PART), .REVISION_IDENTIFIER(REV)) uut (
		.i_clk_sys(clk), .i_reset_n(rst_n), .i_host_select_n(sel_n),
		.i_host_clock(sclk), .i_host_serial_in(host_serial_in),
		.i_host_reset_n(hrst_n), .i_condition(cond),
		.o_host_serial_out(host_serial_out),
		.o_host_serial_out_en(host_serial_out_en),
		.o_irq_n(irq_n), .o_clock_fifo_control(c_fifo),
		.o_timing_mode_control(c_mode), .o_loopback_control(c_loop));
	// released line shows the inverse of host_serial_out, which is zero then
	assign host_serial_line = host_serial_out_en ? host_serial_out
		: ~host_serial_out;
	shrp_host_model host (.i_clk_sys(clk),
		.i_host_serial_out(host_serial_line),
		.o_host_select_n(sel_n), .o_host_clock(sclk),
		.o_host_serial_in(host_serial_in), .o_host_reset_n(hrst_n));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host.xfer({d, 1'b1, a, OP_WRITE}, 16, junk);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.xfer({8'h00, 1'b0, a, OP_READ}, 16, v);
		check(v, exp);
	endtask
	task automatic t_defaults();
		for (int a = 0; a < 6; a++) begin
			rd_chk(6'(a), 8'h00);
		end
		rd_chk(6'h10, 8'h00);
		rd_chk(ADDR_PART_IDENTIFIER, PART);
		rd_chk(ADDR_REVISION_IDENTIFIER, REV);
		$display("defaults test done");
	endtask
	task automatic t_write();
		wr(ADDR_CLOCK_FIFO_CONTROL, 8'hFF);
		wr(ADDR_TIMING_MODE_CONTROL, 8'hFF);
		wr(ADDR_LOOPBACK_CONTROL, 8'hFF);
		wr(6'h10, 8'hFF);
		wr(ADDR_PART_IDENTIFIER, 8'h00);
		check(c_fifo, MASK_CLOCK_FIFO);
		check(c_mode, MASK_TIMING_MODE);
		check(c_loop, MASK_LOOPBACK);
		rd_chk(ADDR_TIMING_MODE_CONTROL, MASK_TIMING_MODE);
		rd_chk(ADDR_CLOCK_FIFO_CONTROL, MASK_CLOCK_FIFO);
		rd_chk(6'h10, 8'h00);
		rd_chk(ADDR_PART_IDENTIFIER, PART);
		host.xfer({8'h00, 1'b0, ADDR_LOOPBACK_CONTROL, OP_WRITE}, 15, junk);
		check(c_loop, MASK_LOOPBACK);
		wr(ADDR_LOOPBACK_CONTROL, 8'h05);
		check(c_loop, 8'h05);
		rd_chk(ADDR_LOOPBACK_CONTROL, 8'h05);
		$display("write test done");
	endtask
	task automatic t_irq();
		for (int k = 0; k < IRQ_SOURCES; k++) begin
			cond[k] = 1'b1;
			repeat (8) @(negedge clk);
			check({7'h00, irq_n}, 8'h01);
			rd_chk(ADDR_LIVE_CONDITION, 8'h01 << k);
			rd_chk(ADDR_IRQ_STATUS, 8'h01 << k);
			rd_chk(ADDR_IRQ_STATUS, 8'h00);
			wr(ADDR_IRQ_ENABLE, 8'h01 << k);
			rd_chk(ADDR_IRQ_ENABLE, 8'h01 << k);
			cond[k] = 1'b0;
			repeat (8) @(negedge clk);
			check({7'h00, irq_n}, 8'h00);
			rd_chk(ADDR_IRQ_STATUS, 8'h01 << k);
			check({7'h00, irq_n}, 8'h01);
			wr(ADDR_IRQ_ENABLE, 8'h00);
		end
		$display("interrupt test done");
	endtask
	task automatic t_hreset();
		host.pulse_reset(HOLD / 2);
		check(c_loop, 8'h05);
		host.pulse_reset(HOLD + 12);
		check(c_loop, 8'h00);
		rd_chk(ADDR_TIMING_MODE_CONTROL, 8'h00);
		$display("host reset test done");
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_defaults();
		t_write();
		t_irq();
		t_hreset();
		summarize();
	end
	initial begin
		#3_000_000;
		miscompares++;
		summarize();
	end
endmodule // testbench
